// File: seb_defs.svh
/*
 * Offsets, field positions, reset values and fixed codes of the scaler
 * event builder and readout block.
 * Assumes it is included by bare name into the package and design files.
 */
`ifndef SEB_DEFS_SVH
`define SEB_DEFS_SVH

// Register offsets (byte addresses of the board's register space)
`define SEB_OFS_GATED_LATCH     16'h009c
`define SEB_OFS_GATE_REF        16'h0204
`define SEB_OFS_FW_VERSION      16'h0400
`define SEB_OFS_SIGNATURE       16'h0404
`define SEB_OFS_READOUT_CLEAR   16'h0500
`define SEB_OFS_READOUT_START   16'h0504
`define SEB_OFS_SVC_MEM_LO      16'h8000
`define SEB_OFS_SVC_MEM_HI      16'h87ff
`define SEB_OFS_SVC_EXEC        16'h9000

// Reset values and gate reference saturation value
`define SEB_RST_FLAGS           8'hff
`define SEB_RST_GATE_REF        32'hffffffff
`define SEB_REF_SATURATED       32'hffffffff

// Builder flag bit positions
`define SEB_FLAG_GREF           4
`define SEB_FLAG_UREF           5
`define SEB_FLAG_LATCH_UNGATED  6
`define SEB_FLAG_LATCH_GATED    7

// Event header fields and section scan sizes
`define SEB_HDR_MARKER          19'h6e500
`define SEB_HDR_SLOT_BAD        5'h1e
`define SEB_SECTION_WORDS       7'h10
`define SEB_SECTION_COUNT       3'h6
`define SEB_LAST_CHANNEL        4'hf

// Word appended after an odd-length event on 64-bit transfers
`define SEB_FILLER_WORD         32'h00000000

// Readout FIFO: seven events of 67 words fit in 512 entries
`define SEB_FIFO_DEPTH          512
`define SEB_FIFO_AW             9

`endif

// File: seb_pkg.sv
/*
 * Types of the scaler event builder and readout block.
 * Assumes seb_defs.svh is on the include path.
 */
`include "seb_defs.svh"

package seb_pkg;

    typedef logic [15:0][31:0] seb_bank_t;

    typedef struct packed {
        logic        last;
        logic [31:0] data;
    } seb_word_s;

    typedef enum logic [1:0] {
        SEB_IDLE,
        SEB_LATCH,
        SEB_HEADER,
        SEB_SCAN
    } seb_build_e;

endpackage

// File: seb_fifo.sv
/*
 * Flip-flop FIFO with valid/ready on both sides, flush and fill count.
 * Assumes one clock and an asynchronous active-high reset.
 */
`timescale 1ns/10ps
`default_nettype none

module seb_fifo #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 512,
    parameter int AW    = 9
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    input  wire logic             flush,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data,
    // Occupancy
    output logic [AW:0]           count
);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;

    assign in_ready  = (count_reg != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
    assign out_valid = (count_reg != '0);
    assign push      = in_valid & in_ready & ~flush;
    assign pop       = out_valid & out_ready & ~flush;
    assign out_data  = mem[rd_ptr_reg];
    assign count     = count_reg;

    // Storage
    always_ff @(posedge core_clk)
    begin
        if (push)
        begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // Pointers and count
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end
        else if (flush)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop)
            begin
                count_reg <= count_reg + 1'b1;
            end
            else if (pop && !push)
            begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// File: seb_event_builder.sv
/*
 * Scaler event builder, readout FIFO path, gate reference counter and
 * identification registers.
 * Assumes scaler banks are latched outside on the latch strobes and are
 * stable one cycle later; the reader side presents A32 data reads.
 */
// Functional notes
// - Gate reference counter counts one per board clock since last gated latch.
// - Counter saturates at all ones; all ones means overflow.
// - Readable gate reference updates only on gated latch write or accepted readout-start with flag 7.
// - Version register read-only: major 15:8, minor 7:0, upper half zero.
// - 2048-byte service memory window reserved, no control function.
// - Single service execute word reserved, separate from registers.
// - A readout-start write accepted while idle builds one event from the written flags.
// - Event appended only with room for all of it; never truncated.
// - FIFO holds seven full events before any readout.
// - FIFO words delivered on the A32 data read port.
// - Word order: header, four 16-word banks, gated ref, ungated ref.
// - Header bits 31:13 carry the fixed marker.
// - Header bits 12:8 slot, or 11110 on parity fault.
// - Header bits 7:0 repeat the triggering flags.
// - Flag bits 0 to 3 each select one 16-word bank.
// - Flag bit 4 adds gated reference, bit 5 ungated reference.
// - On 64-bit reads a filler word pads an odd event.
// - Read past an event's last word ends with bus error.
// - Flag 7 latches gated, flag 6 ungated scalers before words.
// - Readout-clear write empties the FIFO.
// - Readout-start at its own offset; low byte flags, read/write.
`timescale 1ns/10ps
`default_nettype none
`include "seb_defs.svh"

module seb_event_builder #(
    parameter logic [7:0]  VERSION_MAJOR   = 8'h01,
    parameter logic [7:0]  VERSION_MINOR   = 8'h00,
    // Arbitrary signature value
    parameter logic [31:0] SIGNATURE_VALUE = 32'h5eb0c0de
) (
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 sys_rst,
    // Register port
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    input  wire logic [15:0]          reg_addr,
    input  wire logic [31:0]          reg_wdata,
    output logic [31:0]               reg_rdata,
    output logic                      reg_rd_valid,
    // A32 event data read port
    input  wire logic                 rd_ready,
    input  wire logic                 rd_wide,
    output logic                      rd_valid,
    output logic [31:0]               rd_data,
    output logic                      rd_berr,
    // Scaler banks and latch strobes
    input  wire seb_pkg::seb_bank_t   trigger_path_gated,
    input  wire seb_pkg::seb_bank_t   timing_path_gated,
    input  wire seb_pkg::seb_bank_t   trigger_path_ungated,
    input  wire seb_pkg::seb_bank_t   timing_path_ungated,
    input  wire logic [31:0]          ungated_ref_value,
    output logic                      gated_latch_stb,
    output logic                      ungated_latch_stb,
    // Geographic address pins
    input  wire logic [4:0]           geo_slot_pin,
    input  wire logic                 geo_parity_ok_pin
);

    seb_pkg::seb_build_e      state_reg;
    seb_pkg::seb_word_s       push_word;
    seb_pkg::seb_word_s       pop_word;
    logic [7:0]               flags_reg;
    logic [7:0]               cur_flags_reg;
    logic [2:0]               sec_reg;
    logic [3:0]               ch_reg;
    logic [31:0]              gate_ref_cnt_reg;
    logic [31:0]              gate_ref_reg;
    logic [5:0]               geo_s1_reg;
    logic [5:0]               geo_s2_reg;
    logic [5:0]               geo_s3_reg;
    logic [5:0]               geo_reg;
    logic                     end_reg;
    logic                     pad_reg;
    logic                     odd_reg;
    logic                     wr_start;
    logic                     wr_clear;
    logic                     wr_glatch;
    logic                     start_ok;
    logic                     glatch_now;
    logic [6:0]               ev_len;
    logic [`SEB_FIFO_AW:0]    fifo_count;
    logic [`SEB_FIFO_AW:0]    fifo_free;
    logic                     fifo_in_valid;
    logic                     fifo_in_ready;
    logic                     fifo_out_valid;
    logic                     fifo_out_ready;
    logic                     fifo_pop;
    logic                     sec_on;
    logic [5:0]               later_mask;
    logic                     sec_end;
    logic [31:0]              sec_data;
    logic                     in_svc_mem;

    assign wr_start   = reg_wr && reg_addr == `SEB_OFS_READOUT_START;
    assign wr_clear   = reg_wr && reg_addr == `SEB_OFS_READOUT_CLEAR;
    assign wr_glatch  = reg_wr && reg_addr == `SEB_OFS_GATED_LATCH;
    assign in_svc_mem = reg_addr >= `SEB_OFS_SVC_MEM_LO && reg_addr <= `SEB_OFS_SVC_MEM_HI;

    // Event length from the written flags
    always_comb
    begin
        ev_len = 7'h01;
        for (int i = 0; i < 4; i++)
        begin
            if (reg_wdata[i])
            begin
                ev_len = ev_len + `SEB_SECTION_WORDS;
            end
        end
        ev_len = ev_len + {6'h00, reg_wdata[`SEB_FLAG_GREF]}
                        + {6'h00, reg_wdata[`SEB_FLAG_UREF]};
    end

    assign fifo_free  = (`SEB_FIFO_AW+1)'(`SEB_FIFO_DEPTH) - fifo_count;
    assign start_ok   = wr_start && !wr_clear && state_reg == seb_pkg::SEB_IDLE
                        && fifo_free >= {3'h0, ev_len};
    assign glatch_now = wr_glatch || (start_ok && reg_wdata[`SEB_FLAG_LATCH_GATED]);

    // Geographic pins: three flops, change taken once stages two and three agree
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            geo_s1_reg <= '0;
            geo_s2_reg <= '0;
            geo_s3_reg <= '0;
            geo_reg    <= '0;
        end
        else
        begin
            geo_s1_reg <= {geo_parity_ok_pin, geo_slot_pin};
            geo_s2_reg <= geo_s1_reg;
            geo_s3_reg <= geo_s2_reg;
            if (geo_s2_reg == geo_s3_reg)
            begin
                geo_reg <= geo_s3_reg;
            end
        end
    end

    // Gate reference counter and its latched copy
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            gate_ref_cnt_reg <= '0;
            gate_ref_reg     <= `SEB_RST_GATE_REF;
        end
        else if (glatch_now)
        begin
            gate_ref_reg     <= gate_ref_cnt_reg;
            gate_ref_cnt_reg <= '0;
        end
        else if (gate_ref_cnt_reg != `SEB_REF_SATURATED)
        begin
            gate_ref_cnt_reg <= gate_ref_cnt_reg + 32'h00000001;
        end
    end

    // Latch strobes, one cycle each
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            gated_latch_stb   <= 1'b0;
            ungated_latch_stb <= 1'b0;
        end
        else
        begin
            gated_latch_stb   <= glatch_now;
            ungated_latch_stb <= start_ok && reg_wdata[`SEB_FLAG_LATCH_UNGATED];
        end
    end

    // Readout-start flag register
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            flags_reg <= `SEB_RST_FLAGS;
        end
        else if (wr_start)
        begin
            flags_reg <= reg_wdata[7:0];
        end
    end

    // Register reads, answered one cycle after the strobe
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            reg_rdata    <= '0;
            reg_rd_valid <= 1'b0;
        end
        else
        begin
            reg_rd_valid <= reg_rd;
            if (reg_rd)
            begin
                if (in_svc_mem || reg_addr == `SEB_OFS_SVC_EXEC)
                begin
                    reg_rdata <= '0;
                end
                else
                begin
                    unique case (reg_addr)
                        `SEB_OFS_FW_VERSION:    reg_rdata <= {16'h0000, VERSION_MAJOR, VERSION_MINOR};
                        `SEB_OFS_SIGNATURE:     reg_rdata <= SIGNATURE_VALUE;
                        `SEB_OFS_GATE_REF:      reg_rdata <= gate_ref_reg;
                        `SEB_OFS_READOUT_START: reg_rdata <= {24'h000000, flags_reg};
                        default:                reg_rdata <= '0;
                    endcase
                end
            end
        end
    end

    // Section selection inside the scan
    assign sec_on     = sec_reg < `SEB_SECTION_COUNT && cur_flags_reg[sec_reg];
    assign later_mask = 6'(6'h3f << (sec_reg + 3'h1));
    assign sec_end    = sec_reg >= 3'h4 || ch_reg == `SEB_LAST_CHANNEL;

    always_comb
    begin
        unique case (sec_reg)
            3'h0:    sec_data = trigger_path_gated[ch_reg];
            3'h1:    sec_data = timing_path_gated[ch_reg];
            3'h2:    sec_data = trigger_path_ungated[ch_reg];
            3'h3:    sec_data = timing_path_ungated[ch_reg];
            3'h4:    sec_data = gate_ref_reg;
            default: sec_data = ungated_ref_value;
        endcase
    end

    always_comb
    begin
        if (state_reg == seb_pkg::SEB_HEADER)
        begin
            push_word.data = {`SEB_HDR_MARKER,
                              geo_reg[5] ? geo_reg[4:0] : `SEB_HDR_SLOT_BAD,
                              cur_flags_reg};
            push_word.last = cur_flags_reg[5:0] == 6'h00;
        end
        else
        begin
            push_word.data = sec_data;
            push_word.last = sec_end && (cur_flags_reg[5:0] & later_mask) == 6'h00;
        end
    end

    assign fifo_in_valid = state_reg == seb_pkg::SEB_HEADER
                           || (state_reg == seb_pkg::SEB_SCAN && sec_on);

    // Event builder sequence
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_reg     <= seb_pkg::SEB_IDLE;
            cur_flags_reg <= '0;
            sec_reg       <= '0;
            ch_reg        <= '0;
        end
        else if (wr_clear)
        begin
            state_reg <= seb_pkg::SEB_IDLE;
        end
        else
        begin
            unique case (state_reg)
                seb_pkg::SEB_IDLE:
                begin
                    if (start_ok)
                    begin
                        cur_flags_reg <= reg_wdata[7:0];
                        state_reg     <= seb_pkg::SEB_LATCH;
                    end
                end
                seb_pkg::SEB_LATCH:
                begin
                    state_reg <= seb_pkg::SEB_HEADER;
                end
                seb_pkg::SEB_HEADER:
                begin
                    if (fifo_in_ready)
                    begin
                        sec_reg   <= '0;
                        ch_reg    <= '0;
                        state_reg <= seb_pkg::SEB_SCAN;
                    end
                end
                seb_pkg::SEB_SCAN:
                begin
                    if (sec_reg >= `SEB_SECTION_COUNT)
                    begin
                        state_reg <= seb_pkg::SEB_IDLE;
                    end
                    else if (!sec_on)
                    begin
                        sec_reg <= sec_reg + 3'h1;
                    end
                    else if (fifo_in_ready)
                    begin
                        if (sec_end)
                        begin
                            sec_reg <= sec_reg + 3'h1;
                            ch_reg  <= '0;
                        end
                        else
                        begin
                            ch_reg <= ch_reg + 4'h1;
                        end
                    end
                end
            endcase
        end
    end

    // Readout FIFO sized for seven full events
    seb_fifo #(
        .WIDTH ($bits(seb_pkg::seb_word_s)),
        .DEPTH (`SEB_FIFO_DEPTH),
        .AW    (`SEB_FIFO_AW)
    ) u_fifo (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .flush     (wr_clear),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (push_word),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (pop_word),
        .count     (fifo_count)
    );

    // Read port: words, optional filler, then bus error
    assign fifo_out_ready = rd_ready && !pad_reg && !end_reg;
    assign fifo_pop       = fifo_out_ready && fifo_out_valid;
    assign rd_valid       = pad_reg || (!end_reg && fifo_out_valid);
    assign rd_data        = pad_reg ? `SEB_FILLER_WORD : pop_word.data;
    assign rd_berr        = rd_ready && end_reg && !pad_reg;

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            end_reg <= 1'b0;
            pad_reg <= 1'b0;
            odd_reg <= 1'b0;
        end
        else if (wr_clear)
        begin
            end_reg <= 1'b0;
            pad_reg <= 1'b0;
            odd_reg <= 1'b0;
        end
        else if (fifo_pop)
        begin
            odd_reg <= pop_word.last ? 1'b0 : !odd_reg;
            if (pop_word.last)
            begin
                end_reg <= 1'b1;
                pad_reg <= rd_wide && !odd_reg;
            end
        end
        else if (pad_reg && rd_ready)
        begin
            pad_reg <= 1'b0;
        end
        else if (rd_berr)
        begin
            end_reg <= 1'b0;
        end
    end

    // Checks
    AST_GREF_INC: assert property (@(posedge core_clk) disable iff (sys_rst)
        (!glatch_now && gate_ref_cnt_reg != `SEB_REF_SATURATED)
        |=> gate_ref_cnt_reg == $past(gate_ref_cnt_reg) + 32'h00000001)
        else $error("gate reference counter did not advance");
    AST_GREF_SAT: assert property (@(posedge core_clk) disable iff (sys_rst)
        (!glatch_now && gate_ref_cnt_reg == `SEB_REF_SATURATED)
        |=> gate_ref_cnt_reg == `SEB_REF_SATURATED)
        else $error("gate reference counter wrapped");
    AST_GREF_HOLD: assert property (@(posedge core_clk) disable iff (sys_rst)
        !glatch_now |=> $stable(gate_ref_reg))
        else $error("gate reference changed without latch");
    AST_VERSION: assert property (@(posedge core_clk) disable iff (sys_rst)
        (reg_rd && reg_addr == `SEB_OFS_FW_VERSION)
        |=> reg_rd_valid && reg_rdata == {16'h0000, VERSION_MAJOR, VERSION_MINOR})
        else $error("version read wrong");
    AST_SVC_ZERO: assert property (@(posedge core_clk) disable iff (sys_rst)
        (reg_rd && (in_svc_mem || reg_addr == `SEB_OFS_SVC_EXEC)) |=> reg_rdata == 32'h00000000)
        else $error("service space read not zero");
    AST_START: assert property (@(posedge core_clk) disable iff (sys_rst)
        start_ok |=> state_reg == seb_pkg::SEB_LATCH ##1 (state_reg == seb_pkg::SEB_HEADER || $past(wr_clear)))
        else $error("start write did not launch builder");
    AST_NOROOM: assert property (@(posedge core_clk) disable iff (sys_rst)
        (wr_start && state_reg == seb_pkg::SEB_IDLE && fifo_free < {3'h0, ev_len})
        |=> state_reg == seb_pkg::SEB_IDLE && fifo_count == $past(fifo_count) - {9'h0, $past(fifo_pop)})
        else $error("start without room was not ignored");
    AST_HEADER: assert property (@(posedge core_clk) disable iff (sys_rst)
        (fifo_in_valid && state_reg == seb_pkg::SEB_HEADER)
        |-> push_word.data[31:13] == `SEB_HDR_MARKER && push_word.data[7:0] == cur_flags_reg
            && (geo_reg[5] || push_word.data[12:8] == `SEB_HDR_SLOT_BAD))
        else $error("header word malformed");
    AST_CLEAR: assert property (@(posedge core_clk) disable iff (sys_rst)
        wr_clear |=> fifo_count == '0 && !rd_valid)
        else $error("clear did not empty FIFO");
    AST_BERR: assert property (@(posedge core_clk) disable iff (sys_rst)
        (!wr_clear && fifo_pop && pop_word.last && !(rd_wide && !odd_reg)) |=> !rd_valid && end_reg)
        else $error("no bus error after event end");

endmodule

`default_nettype wire

// File: seb_reader.sv
/*
 * Block reader standing in for the bus master on the A32 event port.
 * Assumes the bench raises go once an event is built.
 */
`timescale 1ns/10ps
`default_nettype none

module seb_reader (
    // Clock and control
    input  wire logic  core_clk,
    input  wire logic  go,
    input  wire logic  slow,
    // Event read port
    output logic       rd_ready,
    input  wire logic  rd_valid,
    input  wire logic  [31:0] rd_data,
    input  wire logic  rd_berr,
    // Collected event
    output logic [31:0] words [0:127],
    output int         nwords,
    output logic       done
);
    // One block per event, ended by the bus error
    always_ff @(posedge core_clk)
    begin
        if (!go)
        begin
            rd_ready <= 1'b0;
            nwords   <= 0;
            done     <= 1'b0;
        end
        else
        begin
            if (rd_ready && rd_valid)
                words[nwords] <= rd_data;
            if (rd_ready && rd_valid)
                nwords <= nwords + 1;
            if (rd_ready && rd_berr)
                done <= 1'b1;
            rd_ready <= !done && !(rd_ready && rd_berr) && !(slow && rd_ready && rd_valid);
        end
    end
endmodule

`default_nettype wire

// File: scaler_event_builder_readout_bench.sv
/*
 * Bench: register rows, event rows, clear, fill and slot fault cases.
 * Assumes seb_reader as the block reader.
 */
`timescale 1ns/10ps
`default_nettype none
`include "seb_defs.svh"

module scaler_event_builder_readout_bench;
    typedef struct packed {logic [15:0] a; logic [31:0] d;} seb_reg_row_s;
    typedef struct packed {logic [7:0] f; logic w; logic s;} seb_ev_row_s;
    logic         core_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, rd_wide = 0;
    logic         go = 0, slow = 0, gpar = 1, rd_ready, rd_valid, rd_berr, done, gls, uls, rvld;
    logic [15:0]  reg_addr = 0;
    logic [31:0]  reg_wdata = 0, reg_rdata, rd_data, uref = 32'h50000005, words [0:127], gref = 32'hffffffff;
    logic [4:0]   slot_exp = 5'h0b;
    int           nwords, error_cnt = 0, total_checks = 0, gl_cnt = 0, ul_cnt = 0, cyc = 0, lat_cyc = 0;
    seb_pkg::seb_bank_t bk [4];
    seb_reg_row_s rows [7] = '{'{16'h0400, 32'h00000100}, '{16'h0404, 32'h5eb0c0de},
        '{16'h0204, 32'hffffffff}, '{16'h8000, 32'h0}, '{16'h87fc, 32'h0}, '{16'h9000, 32'h0}, '{16'h0010, 32'h0}};
    seb_ev_row_s  evs [9] = '{'{8'h00, 1'b0, 1'b0}, '{8'h01, 1'b1, 1'b0}, '{8'h02, 1'b0, 1'b1},
        '{8'h04, 1'b0, 1'b0}, '{8'h08, 1'b1, 1'b1}, '{8'h10, 1'b0, 1'b0}, '{8'h20, 1'b1, 1'b0},
        '{8'h4f, 1'b0, 1'b1}, '{8'hbf, 1'b0, 1'b0}};

    seb_event_builder dut (.core_clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .reg_rd_valid(rvld), .rd_ready, .rd_wide, .rd_valid, .rd_data, .rd_berr, .trigger_path_gated(bk[0]),
        .timing_path_gated(bk[1]), .trigger_path_ungated(bk[2]), .timing_path_ungated(bk[3]),
        .ungated_ref_value(uref), .gated_latch_stb(gls), .ungated_latch_stb(uls),
        .geo_slot_pin(5'h0b), .geo_parity_ok_pin(gpar));
    seb_reader rdr (.core_clk, .go, .slow, .rd_ready, .rd_valid, .rd_data, .rd_berr, .words, .nwords, .done);

    initial forever #10 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        gl_cnt += gls;
        ul_cnt += uls;
        cyc++;
    end

    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(logic [15:0] a, logic [31:0] d);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1;
        @(negedge core_clk);
        reg_wr    = 0;
        // Gated reference expected: clocks strictly between two latches
        if (a == 16'h009c || (a == 16'h0504 && d[7]))
        begin
            gref    = 32'(cyc - lat_cyc - 1);
            lat_cyc = cyc;
        end
    endtask

    task automatic rd(logic [15:0] a);
        reg_addr = a;
        reg_rd   = 1;
        @(negedge core_clk);
        chk("read valid", 1, 32'(rvld));
        reg_rd   = 0;
        @(negedge core_clk);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Optionally start a build, then read one block and compare it
    task automatic ev(logic st, logic [7:0] f, logic w, logic s);
        logic [31:0] e [$];
        if (st)
            wr(16'h0504, {24'h0, f});
        e.push_back({`SEB_HDR_MARKER, slot_exp, f});
        for (int k = 0; k < 4; k++)
            for (int c = 0; c < 16 && f[k]; c++)
                e.push_back(bk[k][c]);
        if (f[4])
            e.push_back(gref);
        if (f[5])
            e.push_back(uref);
        if (w && e.size() % 2)
            e.push_back(`SEB_FILLER_WORD);
        repeat (st ? 100 : 1) @(negedge core_clk);
        {rd_wide, slow, go} = {w, s, 1'b1};
        for (int t = 0; t < 400 && !done; t++) @(negedge core_clk);
        chk("bus error", 1, 32'(done));
        if (!done)
            print_verdict();
        chk("event length", 32'(e.size()), 32'(nwords));
        for (int i = 0; i < e.size(); i++)
            chk("event word", e[i], words[i]);
        go = 0;
        @(negedge core_clk);
    endtask

    initial
    begin
        for (int k = 0; k < 4; k++)
            for (int c = 0; c < 16; c++)
                bk[k][c] = {4'(k + 1), 20'h0, 8'(c)};
        repeat (4) @(negedge core_clk);
        sys_rst = 0;
        repeat (8) @(negedge core_clk);
        rd(16'h0504);
        chk("flags", 32'h000000ff, reg_rdata);
        for (int p = 0; p < 2; p++)
            foreach (rows[i])
            begin
                rd(rows[i].a);
                chk("register", rows[i].d, reg_rdata);
                wr(rows[i].a, 32'hffffffff);
            end
        $display("test registers done");
        wr(16'h009c, 0);
        repeat (10) @(negedge core_clk);
        wr(16'h009c, 0);
        rd(16'h0204);
        chk("gate ref", gref, reg_rdata);
        $display("test gate ref done");
        foreach (evs[i])
            ev(1, evs[i].f, evs[i].w, evs[i].s);
        chk("gated strobes", 3, 32'(gl_cnt));
        chk("ungated strobes", 1, 32'(ul_cnt));
        rd(16'h0504);
        chk("flags", 32'h000000bf, reg_rdata);
        $display("test events done");
        wr(16'h0504, 32'h00000001);
        repeat (100) @(negedge core_clk);
        chk("data waiting", 1, 32'(rd_valid));
        wr(16'h0500, 0);
        @(negedge core_clk);
        chk("data after clear", 0, 32'(rd_valid));
        for (int n = 0; n < 8; n++)
        begin
            wr(16'h0504, 32'h0000003f);
            repeat (100) @(negedge core_clk);
        end
        repeat (7) ev(0, 8'h3f, 0, 0);
        chk("refused event", 0, 32'(rd_valid));
        $display("test clear and fill done");
        gpar = 0;
        slot_exp = 5'h1e;
        repeat (8) @(negedge core_clk);
        ev(1, 8'h00, 1, 0);
        $display("test slot fault done");
        sys_rst = 1;
        repeat (2) @(negedge core_clk);
        sys_rst = 0;
        @(negedge core_clk);
        rd(16'h0204);
        chk("gate ref", 32'hffffffff, reg_rdata);
        rd(16'h0504);
        chk("flags", 32'h000000ff, reg_rdata);
        $display("test reset done");
        print_verdict();
    end
endmodule

`default_nettype wire
